// ---- rf_tag_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rf_tag_model
(
  input wire logic clk_sys,
  output logic rx_bit_valid = 1'b0,
  output logic rx_bit,
  output logic rx_frame_end = 1'b0
);
  // --------
  // label reply
  // --------
  logic busy = 1'b0;
  logic data_bit = 1'b0;
  logic idle_bit = 1'b0;
  // idle line toggles so a stale bit never passes for data
  always @(negedge clk_sys)
    idle_bit <= ~idle_bit;
  assign rx_bit = busy ? data_bit : idle_bit;
  task automatic send(input logic [7:0] data);
    busy = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk_sys);
      {rx_bit_valid, data_bit} = {1'b1, data[i]};
      @(negedge clk_sys);
      rx_bit_valid = 1'b0;
    end
    @(negedge clk_sys);
    rx_frame_end = 1'b1;
    @(negedge clk_sys);
    {rx_frame_end, busy} = 2'b00;
  endtask
endmodule // rf_tag_model
`default_nettype wire

// ---- rf_tx_control.v ----
`timescale 1ns/1ps
`default_nettype none
`include "rf_tx_defs.vh"

// What this block does
// - first received bit lands at the programmed alignment bit position
// - later bits go one position higher; alignment 111 wraps to next byte
// - alignment field clears itself when reception ends
// - last byte sends only the programmed bit count; 000 sends all eight
// - final-byte bit count clears itself when transmission ends
// - modulator input: low, high, encoder, or reserved by two-bit select
// - force bit gives full-depth ASK ignoring modulation conductance
// - invert bit makes driver b output the inverted carrier
// - unmodulated bit keeps driver b a plain carrier, else modulation
// - driver b enable gives modulated carrier, else constant level
// - driver a enable gives modulated carrier, else constant level
// - carrier conductance field sets drive strength during carrier
// - modulation conductance field sets drive strength while modulating
module rf_tx_control
(
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  // parallel host port
  input wire [5:0] host_addr,
  input wire host_wr,
  input wire host_rd,
  input wire [7:0] host_wdata,
  output reg [7:0] host_rdata,
  // transmit framing
  input wire tx_byte_valid,
  input wire tx_byte_last,
  input wire [7:0] tx_byte,
  output reg tx_byte_ready,
  input wire tx_encoder_bit,
  output reg tx_bit,
  output reg tx_bit_valid,
  output reg tx_frame_done,
  // receive framing
  input wire rx_bit_valid,
  input wire rx_bit,
  input wire rx_frame_end,
  output reg [7:0] rx_byte,
  output reg rx_byte_valid,
  // carrier and drivers
  input wire carrier,
  output reg modulator_input,
  output reg antenna_driver_a,
  output reg antenna_driver_b,
  output reg [5:0] drive_conductance
);

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  reg [7:0] bit_frame_adjust_reg;
  reg [7:0] transmit_driver_control_reg;
  reg [7:0] carrier_conductance_reg;
  reg [7:0] modulation_conductance_reg;
  wire [2:0] rx_first_bit_position;
  wire [2:0] final_byte_bit_count;
  wire [1:0] modulator_input_select;
  wire full_depth_ask_force;
  wire second_driver_invert;
  wire second_driver_unmodulated;
  wire second_driver_rf_enable;
  wire first_driver_rf_enable;
  wire [5:0] carrier_drive_conductance;
  wire [5:0] modulation_drive_conductance;
  assign rx_first_bit_position =
    bit_frame_adjust_reg[`RX_ALIGN_MSB:`RX_ALIGN_LSB];
  assign final_byte_bit_count =
    bit_frame_adjust_reg[`TX_LAST_MSB:`TX_LAST_LSB];
  assign modulator_input_select =
    transmit_driver_control_reg[`MOD_SRC_MSB:`MOD_SRC_LSB];
  assign full_depth_ask_force = transmit_driver_control_reg[`FORCE_ASK_BIT];
  assign second_driver_invert = transmit_driver_control_reg[`TX2_INV_BIT];
  assign second_driver_unmodulated = transmit_driver_control_reg[`TX2_CW_BIT];
  assign second_driver_rf_enable = transmit_driver_control_reg[`TX2_RFEN_BIT];
  assign first_driver_rf_enable = transmit_driver_control_reg[`TX1_RFEN_BIT];
  assign carrier_drive_conductance = carrier_conductance_reg[`COND_MSB:0];
  assign modulation_drive_conductance =
    modulation_conductance_reg[`COND_MSB:0];

  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  reg [2:0] rx_meta_reg;
  reg [2:0] rx_sync_reg;
  reg carrier_meta_reg;
  reg carrier_sync_reg;
  wire rx_valid_s;
  wire rx_bit_s;
  wire rx_end_s;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_meta_reg <= 3'h0;
      rx_sync_reg <= 3'h0;
      carrier_meta_reg <= 1'b0;
      carrier_sync_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_meta_reg <= {rx_frame_end, rx_bit, rx_bit_valid};
      rx_sync_reg <= rx_meta_reg;
      carrier_meta_reg <= carrier;
      carrier_sync_reg <= carrier_meta_reg;
    end
  end

  assign rx_valid_s = rx_sync_reg[0];
  assign rx_bit_s = rx_sync_reg[1];
  assign rx_end_s = rx_sync_reg[2];

  // -------------------------------------------------------------------
  // transmit serialiser
  // -------------------------------------------------------------------
  localparam TX_IDLE = 1'b0;
  localparam TX_SHIFT = 1'b1;
  reg tx_state_reg;
  reg [7:0] tx_shift_reg;
  reg [3:0] tx_left_reg;
  reg tx_last_reg;
  reg tx_end_pulse;
  wire [3:0] tx_bits_this_byte;
  assign tx_bits_this_byte = (tx_byte_last && final_byte_bit_count != 3'h0)
    ? {1'b0, final_byte_bit_count} : 4'h8;
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 8'h00;
      tx_left_reg <= 4'h0;
      tx_last_reg <= 1'b0;
      tx_end_pulse <= 1'b0;
      tx_byte_ready <= 1'b0;
      tx_bit <= 1'b0;
      tx_bit_valid <= 1'b0;
      tx_frame_done <= 1'b0;
    end
    else if (clk_en)
    begin
      tx_end_pulse <= 1'b0;
      tx_frame_done <= 1'b0;
      tx_bit_valid <= 1'b0;
      tx_byte_ready <= 1'b0;
      case (tx_state_reg)
        TX_IDLE:
        begin
          if (tx_byte_valid && !tx_byte_ready)
          begin
            tx_byte_ready <= 1'b1;
            tx_shift_reg <= tx_byte;
            tx_left_reg <= tx_bits_this_byte;
            tx_last_reg <= tx_byte_last;
            tx_state_reg <= TX_SHIFT;
          end
        end
        TX_SHIFT:
        begin
          tx_bit <= tx_shift_reg[0];
          tx_bit_valid <= 1'b1;
          tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
          tx_left_reg <= tx_left_reg - 4'h1;
          if (tx_left_reg == 4'h1)
          begin
            tx_state_reg <= TX_IDLE;
            if (tx_last_reg)
            begin
              tx_frame_done <= 1'b1;
              tx_end_pulse <= 1'b1;
            end
          end
        end
        default:
          tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // receive aligner
  // -------------------------------------------------------------------
  reg [2:0] rx_pos_reg;
  reg rx_active_reg;
  reg rx_end_pulse;
  wire [2:0] rx_pos_now;
  assign rx_pos_now = rx_active_reg ? rx_pos_reg : rx_first_bit_position;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_pos_reg <= 3'h0;
      rx_active_reg <= 1'b0;
      rx_end_pulse <= 1'b0;
      rx_byte <= 8'h00;
      rx_byte_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_byte_valid <= 1'b0;
      rx_end_pulse <= 1'b0;
      if (rx_valid_s)
      begin
        rx_byte[rx_pos_now] <= rx_bit_s;
        rx_active_reg <= 1'b1;
        rx_pos_reg <= rx_pos_now + 3'h1;
        if (rx_pos_now == 3'h7)
          rx_byte_valid <= 1'b1;
        if (rx_pos_now == 3'h0)
          rx_byte <= {7'h00, rx_bit_s};
      end
      else if (rx_end_s && rx_active_reg)
      begin
        rx_active_reg <= 1'b0;
        rx_end_pulse <= 1'b1;
        if (rx_pos_reg != 3'h0)
          rx_byte_valid <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------
  // host register access
  // -------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_frame_adjust_reg <= `RST_BIT_FRAME_ADJUST;
      transmit_driver_control_reg <= `RST_TRANSMIT_DRIVER_CONTROL;
      carrier_conductance_reg <= `RST_CARRIER_CONDUCTANCE;
      modulation_conductance_reg <= `RST_MODULATION_CONDUCTANCE;
      host_rdata <= 8'h00;
    end
    else if (clk_en)
    begin
      if (host_wr)
      begin
        case (host_addr)
          `ADDR_BIT_FRAME_ADJUST:
            bit_frame_adjust_reg <= host_wdata;
          `ADDR_TRANSMIT_DRIVER_CONTROL:
            transmit_driver_control_reg <= host_wdata;
          `ADDR_CARRIER_CONDUCTANCE:
            carrier_conductance_reg <= host_wdata;
          `ADDR_MODULATION_CONDUCTANCE:
            modulation_conductance_reg <= host_wdata;
          default:
            bit_frame_adjust_reg <= bit_frame_adjust_reg;
        endcase
      end
      // hardware clear wins over a same-cycle write
      // clear alignment and final-byte bit count
      if (rx_end_pulse)
        bit_frame_adjust_reg[`RX_ALIGN_MSB:`RX_ALIGN_LSB] <= 3'h0;
      if (tx_end_pulse)
        bit_frame_adjust_reg[`TX_LAST_MSB:`TX_LAST_LSB] <= 3'h0;
      if (host_rd)
      begin
        case (host_addr)
          `ADDR_BIT_FRAME_ADJUST: host_rdata <= bit_frame_adjust_reg;
          `ADDR_TRANSMIT_DRIVER_CONTROL:
            host_rdata <= transmit_driver_control_reg;
          `ADDR_CARRIER_CONDUCTANCE: host_rdata <= carrier_conductance_reg;
          `ADDR_MODULATION_CONDUCTANCE:
            host_rdata <= modulation_conductance_reg;
          default: host_rdata <= 8'h00;
        endcase
      end
    end
  end

  // -------------------------------------------------------------------
  // modulator and antenna drivers
  // -------------------------------------------------------------------
  reg mod_next;
  reg mod_b_next;
  reg carrier_b;
  always @*
  begin
    case (modulator_input_select)
      `MOD_SRC_LOW: mod_next = 1'b0;
      `MOD_SRC_HIGH: mod_next = 1'b1;
      `MOD_SRC_ENCODER: mod_next = tx_encoder_bit;
      default: mod_next = 1'b0;
    endcase
    mod_b_next = second_driver_unmodulated ? 1'b0 : mod_next;
    carrier_b = second_driver_invert ? ~carrier_sync_reg : carrier_sync_reg;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modulator_input <= 1'b0;
      antenna_driver_a <= 1'b0;
      antenna_driver_b <= 1'b0;
      drive_conductance <= 6'h00;
    end
    else if (clk_en)
    begin
      modulator_input <= mod_next;
      antenna_driver_a <= first_driver_rf_enable &
        (carrier_sync_reg & ~(mod_next & full_depth_ask_force));
      antenna_driver_b <= second_driver_rf_enable &
        (carrier_b & ~(mod_b_next & full_depth_ask_force));
      if (mod_next && full_depth_ask_force)
        drive_conductance <= 6'h00;
      else if (mod_next)
        drive_conductance <= modulation_drive_conductance;
      else
        drive_conductance <= carrier_drive_conductance;
    end
  end

endmodule // rf_tx_control
`default_nettype wire

// ---- rf_tx_control_and_bit_framing_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rf_tx_defs.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module rf_tx_control_and_bit_framing_tb;
  logic clk_sys, rst_n, host_wr, host_rd, tx_byte_valid, tx_byte_last;
  logic tx_encoder_bit, rx_bit_valid, rx_bit, rx_frame_end, carrier, clk_en;
  logic tx_byte_ready, tx_bit, tx_bit_valid, tx_frame_done, rx_byte_valid;
  logic modulator_input, antenna_driver_a, antenna_driver_b;
  logic [5:0] host_addr, drive_conductance;
  logic [7:0] host_wdata, host_rdata, tx_byte, rx_byte, rd, d, e;
  logic [2:0] hist, n;
  logic txq[$];
  logic [7:0] rxq[$];
  int num_errors = 0;
  int cmp_count = 0;
  localparam logic [5:0] adr_frm = `ADDR_BIT_FRAME_ADJUST;
  localparam logic [5:0] adr_ctl = `ADDR_TRANSMIT_DRIVER_CONTROL;
  localparam logic [5:0] adr_cw = `ADDR_CARRIER_CONDUCTANCE;
  localparam logic [5:0] adr_md = `ADDR_MODULATION_CONDUCTANCE;
  logic [5:0] ra[5] = '{adr_frm, adr_ctl, adr_cw, adr_md, 6'h3f};
  logic [7:0] rv[5] = '{`RST_BIT_FRAME_ADJUST, `RST_TRANSMIT_DRIVER_CONTROL,
    `RST_CARRIER_CONDUCTANCE, `RST_MODULATION_CONDUCTANCE, 8'h00};
  rf_tx_control i_dut (.clk_sys, .rst_n, .clk_en, .host_addr, .host_wr,
    .host_rd, .host_wdata, .host_rdata, .tx_byte_valid, .tx_byte_last,
    .tx_byte, .tx_byte_ready, .tx_encoder_bit, .tx_bit, .tx_bit_valid,
    .tx_frame_done, .rx_bit_valid, .rx_bit, .rx_frame_end, .rx_byte,
    .rx_byte_valid, .carrier, .modulator_input, .antenna_driver_a,
    .antenna_driver_b, .drive_conductance);
  rf_tag_model i_tag (.clk_sys, .rx_bit_valid, .rx_bit, .rx_frame_end);
  // --------
  // clock, carrier and capture
  // --------
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys)
  begin
    hist <= {hist[1:0], carrier};
    carrier <= 1'($urandom);
  end
  always @(posedge clk_sys)
  begin
    if (tx_bit_valid === 1'b1) txq.push_back(tx_bit);
    if (rx_byte_valid === 1'b1) rxq.push_back(rx_byte);
  end
  function automatic logic exp_mod(input logic [1:0] s, input logic enc);
    return s == `MOD_SRC_HIGH ? 1'b1 : s == `MOD_SRC_ENCODER ? enc : 1'b0;
  endfunction
  // drive strength: none under forced full depth, else by modulation state
  function automatic logic [5:0] exp_gs(input logic m, input logic f,
    input logic [7:0] cw, input logic [7:0] md);
    return (m && f) ? 6'h00 : m ? md[5:0] : cw[5:0];
  endfunction
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    {host_addr, host_wdata, host_wr} = {a, v, 1'b1};
    @(negedge clk_sys);
    host_wr = 1'b0;
  endtask
  task automatic rdr(input logic [5:0] a);
    @(negedge clk_sys);
    {host_addr, host_rd} = {a, 1'b1};
    @(negedge clk_sys);
    host_rd = 1'b0;
    @(negedge clk_sys);
    rd = host_rdata;
  endtask
  // valid stays up across both bytes, data swaps after the first take
  task automatic tx_send(input logic [7:0] b0, input logic [7:0] b1);
    @(negedge clk_sys);
    {tx_byte, tx_byte_last, tx_byte_valid} = {b0, 2'b01};
    for (int k = 0; k < 2; k++)
    begin
      for (int w = 0; w < 40 && tx_byte_ready !== 1'b1; w++)
        @(posedge clk_sys);
      `CHK(tx_byte_ready, 1'b1)
      @(negedge clk_sys);
      {tx_byte, tx_byte_last} = {b1, 1'b1};
    end
    tx_byte_valid = 1'b0;
    for (int w = 0; w < 40 && tx_frame_done !== 1'b1; w++)
      @(posedge clk_sys);
    `CHK(tx_frame_done, 1'b1)
  endtask
  task automatic end_sim;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // --------
  // tests
  // --------
  initial
  begin
    {host_wr, host_rd, tx_byte_valid, tx_byte_last, tx_encoder_bit} = '0;
    {host_addr, host_wdata, tx_byte, rst_n} = '0;
    clk_en = 1'b1;
    void'($urandom(32754));
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    foreach (ra[i])
    begin
      rdr(ra[i]);
      `CHK(rd, rv[i])
    end
    $display("reset values done");
    repeat (6)
    begin
      d = 8'($urandom) & 8'h3f;
      e = 8'($urandom) & 8'h7f;
      wr(adr_cw, d);
      wr(adr_md, ~d & 8'h3f);
      wr(adr_ctl, e);
      rdr(adr_cw);
      `CHK(rd, d)
      rdr(adr_md);
      `CHK(rd, ~d & 8'h3f)
      rdr(adr_ctl);
      `CHK(rd, e)
    end
    $display("register access done");
    for (int k = 0; k < 8; k++)
    begin
      wr(adr_ctl, {1'b0, 2'(k >> 1), 5'h00});
      tx_encoder_bit = k[0];
      repeat (3) @(negedge clk_sys);
      `CHK(modulator_input, exp_mod(2'(k >> 1), k[0]))
    end
    $display("modulator source done");
    for (int k = 0; k < 2; k++)
    begin
      wr(adr_ctl, 8'h06 | 8'(k << 3));
      repeat (8)
      begin
        @(negedge clk_sys);
        `CHK(antenna_driver_b, hist[1] ^ k[0])
        `CHK(antenna_driver_a, 1'b0)
      end
    end
    $display("antenna drivers done");
    for (int k = 0; k < 8; k++)
    begin
      d = 8'($urandom) & 8'h3f;
      e = ~d & 8'h3f;
      wr(adr_cw, d);
      wr(adr_md, e);
      wr(adr_ctl, {1'b0, 1'b0, k[0], k[1], 1'b0, k[2], 2'b11});
      repeat (4)
      begin
        @(negedge clk_sys);
        `CHK(drive_conductance, exp_gs(k[0], k[1], d, e))
        `CHK(antenna_driver_a, hist[1] & ~(k[0] & k[1]))
        `CHK(antenna_driver_b, hist[1] & ~(k[0] & k[1] & ~k[2]))
      end
    end
    $display("drive strength done");
    clk_en = 1'b0;
    wr(adr_cw, e);
    clk_en = 1'b1;
    rdr(adr_cw);
    `CHK(rd, d)
    $display("clock enable done");
    for (int t = 0; t < 4; t++)
    begin
      n = t < 3 ? 3'(t * 7 / 2) : 3'($urandom_range(6, 1));
      wr(adr_frm, {5'h00, n});
      d = 8'($urandom);
      e = 8'($urandom);
      txq.delete();
      tx_send(d, e);
      rdr(adr_frm);
      `CHK(rd, 8'h00)
      `CHK(txq.size(), n == 0 ? 16 : 8 + n)
      foreach (txq[i])
        `CHK(txq[i], i < 8 ? d[i] : e[i - 8])
    end
    $display("transmit framing done");
    for (int a = 0; a < 8; a++)
    begin
      wr(adr_frm, 8'(a << 4));
      d = 8'($urandom);
      rxq.delete();
      i_tag.send(d);
      repeat (6) @(negedge clk_sys);
      `CHK(rxq.size(), a == 0 ? 1 : 2)
      `CHK(rxq[0] & (8'hff << a), 8'(d << a))
      if (a > 0)
        `CHK(rxq[1] & (8'hff >> (8 - a)), d >> (8 - a))
      rdr(adr_frm);
      `CHK(rd, 8'h00)
    end
    $display("receive alignment done");
    end_sim();
  end
  // tests need about 6 us, so this only trips on a hang
  initial
  begin
    #200us;
    num_errors++;
    end_sim();
  end
endmodule // rf_tx_control_and_bit_framing_tb
`default_nettype wire

// ---- rf_tx_defs.vh ----
`ifndef RF_TX_DEFS_VH
`define RF_TX_DEFS_VH
// register offsets
`define ADDR_BIT_FRAME_ADJUST 6'h0f
`define ADDR_TRANSMIT_DRIVER_CONTROL 6'h11
`define ADDR_CARRIER_CONDUCTANCE 6'h12
`define ADDR_MODULATION_CONDUCTANCE 6'h13
// reset values
`define RST_BIT_FRAME_ADJUST 8'h00
`define RST_TRANSMIT_DRIVER_CONTROL 8'h48
`define RST_CARRIER_CONDUCTANCE 8'h3f
`define RST_MODULATION_CONDUCTANCE 8'h05
// field positions
`define RX_ALIGN_MSB 6
`define RX_ALIGN_LSB 4
`define TX_LAST_MSB 2
`define TX_LAST_LSB 0
`define MOD_SRC_MSB 6
`define MOD_SRC_LSB 5
`define FORCE_ASK_BIT 4
`define TX2_INV_BIT 3
`define TX2_CW_BIT 2
`define TX2_RFEN_BIT 1
`define TX1_RFEN_BIT 0
`define COND_MSB 5
// modulator source codes
`define MOD_SRC_LOW 2'h0
`define MOD_SRC_HIGH 2'h1
`define MOD_SRC_ENCODER 2'h2
`endif

// ---- rf_tx_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module rf_tx_monitor
(
  input wire clk_sys,
  input wire rst_n,
  input wire host_rd,
  input wire [7:0] host_rdata,
  input wire tx_byte_valid,
  input wire tx_byte_ready,
  input wire tx_bit_valid,
  input wire tx_frame_done,
  input wire rx_bit_valid,
  input wire rx_frame_end,
  input wire rx_byte_valid
);
  // --------
  // bit and gap counts
  // --------
  logic [3:0] bit_cnt;
  logic [3:0] rx_gap;
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      {bit_cnt, rx_gap} <= 8'h0f;
    else
    begin
      bit_cnt <= (tx_byte_ready ? 4'h0 : bit_cnt) + {3'h0, tx_bit_valid};
      if (rx_bit_valid || rx_frame_end)
        rx_gap <= 4'h0;
      else if (rx_gap != 4'hf)
        rx_gap <= rx_gap + 4'h1;
    end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_ready_drop;
    ##1 !tx_byte_ready;
  endsequence
  sequence s_bits_start;
    ##[0:2] tx_bit_valid;
  endsequence
  a_ready_one_cycle: assert property (
    tx_byte_ready |-> s_ready_drop) else $error("ready too long");
  a_ready_after_offer: assert property (
    tx_byte_ready |-> $past(tx_byte_valid)) else $error("ready unasked");
  a_bits_follow_take: assert property (
    tx_byte_ready |-> s_bits_start) else $error("no bits after take");
  a_byte_bit_limit: assert property (
    tx_bit_valid && !tx_byte_ready |-> bit_cnt < 4'h8)
    else $error("more than eight bits");
  a_done_with_bit: assert property (
    tx_frame_done |-> tx_bit_valid) else $error("done without bit");
  a_done_then_quiet: assert property (
    tx_frame_done |=> !tx_frame_done && !tx_bit_valid)
    else $error("bits after done");
  a_rdata_on_read: assert property (
    !$stable(host_rdata) |-> $past(host_rd)) else $error("rdata moved");
  a_rx_byte_cause: assert property (
    rx_byte_valid |-> rx_gap < 4'h7) else $error("stray rx byte");
endmodule // rf_tx_monitor
bind rf_tx_control rf_tx_monitor i_mon (.clk_sys, .rst_n, .host_rd,
  .host_rdata, .tx_byte_valid, .tx_byte_ready, .tx_bit_valid,
  .tx_frame_done, .rx_bit_valid, .rx_frame_end, .rx_byte_valid);
`default_nettype wire
